// ---- hdl/gsp_dev.sv ----
// device end: serial register port of a self-running rate sensor
// assumes the link pins come from another clock domain and are
// oversampled by clk_sys_i, at least 20 system cycles per half sclk
// Operation
// - later output bits shift on falling sclk
// - input bits sampled on rising sclk
// - chip select low activates, high ignores traffic
// - 16-bit registers, two 7-bit byte addresses
// - sampling and loading start without configuration
// - sample done line pulses each sample cycle
// - master uses mode 3, msb first, 16 bits
// - master serial clock at most 2.5 MHz
// - read takes request frame then response frame
// - read request: address in upper byte
// - full duplex: response shifts while next arrives
// - drive response only after a read frame
// - output released while chip select high
// - msb appears at chip select falling edge
// - master stalls at least 9 us between frames
// - upper byte address is lower plus one
`timescale 1ns/10ps
module gsp_dev
	import gsp_pkg::*;
#(
	parameter int SAMPLE_CYC = GSP_SAMPLE_CYC,
	parameter int DONE_PULSE_CYC = GSP_DONE_PULSE_CYC
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// serial link
	gsp_spi_if.dev spi,
	// fresh sensor words, taken at each sample cycle end
	input wire logic [15:0] gyro_sample_i,
	input wire logic [15:0] rate_ext_sample_i,
	input wire logic [15:0] temp_sample_i,
	// byte writes seen by the rest of the sensor
	output logic cfg_wr_o,
	output logic [6:0] cfg_addr_o,
	output logic [7:0] cfg_data_o,
	// internal sample cycle end, one cycle
	output logic sample_tick_o
);

	localparam int SMP_W = $clog2(SAMPLE_CYC + 1);
	localparam int PLS_W = $clog2(DONE_PULSE_CYC + 1);
	localparam int CNT_W = $clog2(GSP_FRAME_BITS);

	// synchroniser stages, first stage read only by the second
	logic [1:0] sclk_sync_ff;
	logic [1:0] cs_sync_ff;
	logic [1:0] mosi_sync_ff;
	logic sclk_d_ff;
	logic cs_d_ff;
	logic sclk_s;
	logic cs_s;
	logic mosi_s;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic active;

	// frame state
	logic [CNT_W-1:0] bit_cnt_ff;
	logic [15:0] rx_ff;
	logic [15:0] rx_word;
	logic frame_done;
	logic frame_is_write;
	logic [6:0] frame_addr;
	logic [15:0] tx_ff;
	logic [15:0] resp_word_ff;
	logic resp_pend_ff;
	logic drive_ff;
	logic wr_en;

	// register store and sample timer
	logic [15:0] regs_ff [GSP_REG_WORDS];
	logic [SMP_W-1:0] smp_cnt_ff;
	logic smp_tick;
	logic [PLS_W-1:0] pulse_cnt_ff;
	logic done_line_ff;

	// two-flop synchronisers for the link pins
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_sync_ff <= 2'b11;
			cs_sync_ff <= 2'b11;
			mosi_sync_ff <= 2'b00;
			sclk_d_ff <= 1'b1;
			cs_d_ff <= 1'b1;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[0], spi.sclk};
			cs_sync_ff <= {cs_sync_ff[0], spi.cs_n};
			mosi_sync_ff <= {mosi_sync_ff[0], spi.mosi};
			sclk_d_ff <= sclk_sync_ff[1];
			cs_d_ff <= cs_sync_ff[1];
		end
	end

	// edge detection on the settled copies only
	assign sclk_s = sclk_sync_ff[1];
	assign cs_s = cs_sync_ff[1];
	assign mosi_s = mosi_sync_ff[1];
	assign sclk_rise = sclk_s & ~sclk_d_ff;
	assign sclk_fall = ~sclk_s & sclk_d_ff;
	assign cs_fall = ~cs_s & cs_d_ff;
	// traffic counts only with chip select low
	assign active = ~cs_s;

	// bit counter, restarted whenever chip select is high
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bit_cnt_ff <= '0;
		end else if (!active) begin
			bit_cnt_ff <= '0;
		end else if (sclk_rise) begin
			bit_cnt_ff <= bit_cnt_ff + 1'b1; // wraps to zero after the last bit
		end
	end

	// receive shifter, msb first
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_ff <= 16'h0000;
		end else if (active && sclk_rise) begin
			rx_ff <= rx_word;
		end
	end

	// a frame ends on its sixteenth rising edge
	assign rx_word = {rx_ff[14:0], mosi_s};
	assign frame_done = active & sclk_rise & (bit_cnt_ff == CNT_W'(GSP_FRAME_BITS - 1));
	assign frame_is_write = rx_word[GSP_RW_BIT];
	assign frame_addr = rx_word[GSP_ADDR_MSB:GSP_ADDR_LSB];

	// response capture for the next frame
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			resp_word_ff <= 16'h0000;
			resp_pend_ff <= 1'b0;
		end else if (frame_done) begin
			resp_pend_ff <= ~frame_is_write;
			if (!frame_is_write) begin
				resp_word_ff <= regs_ff[frame_addr[6:1]];
			end
		end
	end

	// transmit shifter; a partial frame leaves the pending answer alone
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_ff <= 16'h0000;
		end else if (cs_fall) begin
			tx_ff <= resp_word_ff;
		end else if (active && sclk_fall && bit_cnt_ff != '0) begin
			// the first falling edge precedes any capture, so no shift there
			tx_ff <= {tx_ff[14:0], 1'b0};
		end
	end

	// output driver enable
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			drive_ff <= 1'b0;
		end else if (!active) begin
			drive_ff <= 1'b0;
		// answer goes out during the next frame
		end else if (cs_fall) begin
			drive_ff <= resp_pend_ff;
		end
	end

	assign spi.miso_out = tx_ff[15];
	assign spi.miso_oen_n = ~drive_ff;

	// writes reach only the configuration part of the map, byte addresses 0x14 and up
	// top bit one is a byte write
	assign wr_en = frame_done & frame_is_write & (frame_addr >= GSP_ADDR_RW_FIRST);

	// register store: sample loads and byte writes never hit the same word
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < GSP_REG_WORDS; i++) begin
				regs_ff[i] <= gsp_reset_val(6'(i));
			end
		end else begin
			if (smp_tick) begin
				regs_ff[GSP_ADDR_GYRO[6:1]] <= gyro_sample_i;
				regs_ff[GSP_ADDR_RATE_EXT[6:1]] <= rate_ext_sample_i;
				regs_ff[GSP_ADDR_TEMP[6:1]] <= temp_sample_i;
			end
			if (wr_en) begin
				if (frame_addr[0]) begin
					regs_ff[frame_addr[6:1]][15:8] <= rx_word[7:0];
				end else begin
					regs_ff[frame_addr[6:1]][7:0] <= rx_word[7:0];
				end
			end
		end
	end

	// write notification for the rest of the sensor
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_wr_o <= 1'b0;
			cfg_addr_o <= 7'h00;
			cfg_data_o <= 8'h00;
		end else begin
			cfg_wr_o <= wr_en;
			if (wr_en) begin
				cfg_addr_o <= frame_addr;
				cfg_data_o <= rx_word[7:0];
			end
		end
	end

	// free-running sample cycle timer, no setup needed after reset
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			smp_cnt_ff <= '0;
		end else if (smp_tick) begin
			smp_cnt_ff <= '0;
		end else begin
			smp_cnt_ff <= smp_cnt_ff + 1'b1;
		end
	end

	assign smp_tick = (smp_cnt_ff == SMP_W'(SAMPLE_CYC - 1));

	// stretched done pulse, so a slow sampler on the far side sees it
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pulse_cnt_ff <= '0;
			done_line_ff <= 1'b0;
			sample_tick_o <= 1'b0;
		end else begin
			sample_tick_o <= smp_tick;
			if (smp_tick) begin
				pulse_cnt_ff <= PLS_W'(DONE_PULSE_CYC - 1);
				done_line_ff <= 1'b1;
			end else if (pulse_cnt_ff != '0) begin
				pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
			end else begin
				done_line_ff <= 1'b0;
			end
		end
	end

	assign spi.sample_done_line = done_line_ff;

endmodule

// ---- hdl/gsp_pkg.sv ----
// shared constants for the rate sensor serial register port
// assumes a 100 MHz system clock on both ends of the link
package gsp_pkg;

	// system clock and serial frame shape
	localparam int GSP_CLK_HZ = 100_000_000;
	localparam int GSP_FRAME_BITS = 16;
	localparam int GSP_ADDR_W = 7;
	localparam int GSP_WORD_W = 16;
	localparam int GSP_REG_WORDS = 64;

	// frame field positions
	localparam int GSP_RW_BIT = 15;
	localparam int GSP_ADDR_MSB = 14;
	localparam int GSP_ADDR_LSB = 8;

	// serial clock ceiling and derived half period, rounded up
	localparam int GSP_SCLK_MAX_KHZ = 2500;
	localparam int GSP_SCLK_HALF_CYC = (GSP_CLK_HZ / 1000 + 2 * GSP_SCLK_MAX_KHZ - 1)
		/ (2 * GSP_SCLK_MAX_KHZ);

	// least chip select high time between frames, in microseconds and in system cycles
	localparam int GSP_STALL_US = 9;
	localparam int GSP_STALL_CYC = GSP_STALL_US * (GSP_CLK_HZ / 1_000_000);

	// chip select to first clock edge, in picoseconds, rounded up
	localparam int GSP_CS_SETUP_PS = 48_800;
	localparam int GSP_CS_SETUP_CYC = (GSP_CS_SETUP_PS + 9_999) / 10_000;

	// host timer width, large enough for the stall count
	localparam int GSP_TMR_W = 10;

	// internal sample rate and cycle count per sample, rounded down
	localparam int GSP_SAMPLE_SPS = 2429;
	localparam int GSP_SAMPLE_CYC = GSP_CLK_HZ / GSP_SAMPLE_SPS;
	localparam int GSP_DONE_PULSE_CYC = 4;

	// register byte addresses of the lower bytes
	localparam logic [6:0] GSP_ADDR_GYRO = 7'h04;
	localparam logic [6:0] GSP_ADDR_RATE_EXT = 7'h06;
	localparam logic [6:0] GSP_ADDR_TEMP = 7'h0C;
	localparam logic [6:0] GSP_ADDR_SCALE = 7'h16;
	localparam logic [6:0] GSP_ADDR_MISC = 7'h34;
	localparam logic [6:0] GSP_ADDR_AVG = 7'h38;
	localparam logic [6:0] GSP_ADDR_PROD = 7'h56;
	localparam logic [6:0] GSP_ADDR_RW_FIRST = 7'h14;

	// register reset values
	localparam logic [15:0] GSP_RST_SCALE = 16'h0800;
	localparam logic [15:0] GSP_RST_MISC = 16'h0006;
	localparam logic [15:0] GSP_RST_AVG = 16'h0401;
	// product code: value is arbitrary
	localparam logic [15:0] GSP_RST_PROD = 16'h1234;

	// reset value of one register word, by word index
	function automatic logic [15:0] gsp_reset_val(input logic [5:0] idx);
		logic [15:0] val;
		val = 16'h0000;
		if (idx == GSP_ADDR_SCALE[6:1]) val = GSP_RST_SCALE;
		if (idx == GSP_ADDR_MISC[6:1]) val = GSP_RST_MISC;
		if (idx == GSP_ADDR_AVG[6:1]) val = GSP_RST_AVG;
		if (idx == GSP_ADDR_PROD[6:1]) val = GSP_RST_PROD;
		return val;
	endfunction

endpackage

// ---- hdl/gsp_spi_if.sv ----
// four-wire serial link between the host end and the device end
// assumes a pull-up on the data output line when no device drives it
`timescale 1ns/10ps
interface gsp_spi_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso_out;
	logic miso_oen_n;
	logic miso_line;
	logic sample_done_line;

	// resolved data output wire, pulled high while released
	assign miso_line = miso_oen_n ? 1'b1 : miso_out;

	modport dev (
		input sclk,
		input cs_n,
		input mosi,
		output miso_out,
		output miso_oen_n,
		output sample_done_line
	);

	modport host (
		output sclk,
		output cs_n,
		output mosi,
		input miso_line,
		input sample_done_line
	);
endinterface

// ---- hdl/gsp_host.sv ----
// host end: frame master for the sensor register port
// assumes one request word per frame from same-clock user logic;
// the sensor answer and done line arrive asynchronously
`timescale 1ns/10ps
module gsp_host
	import gsp_pkg::*;
#(
	parameter int SCLK_HALF_CYC = GSP_SCLK_HALF_CYC,
	parameter int STALL_CYC = GSP_STALL_CYC,
	parameter int CS_SETUP_CYC = GSP_CS_SETUP_CYC
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// serial link
	gsp_spi_if.host spi,
	// frame request
	input wire logic req_valid_i,
	input wire logic [15:0] req_word_i,
	output logic req_ready_o,
	// word shifted in during each frame
	output logic resp_valid_o,
	output logic [15:0] resp_word_o,
	// sensor sample done, one cycle per rising edge
	output logic data_ready_o
);

	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_SETUP = 3'b001,
		H_LOW = 3'b010,
		H_HIGH = 3'b011,
		H_HOLD = 3'b100,
		H_STALL = 3'b101
	} gsp_hst_e;

	localparam int CNT_W = $clog2(GSP_FRAME_BITS);

	gsp_hst_e state_ff;
	logic [GSP_TMR_W-1:0] tmr_ff;
	logic [CNT_W-1:0] bit_cnt_ff;
	logic [15:0] sh_ff;
	logic [15:0] rx_ff;
	logic sclk_ff;
	logic cs_n_ff;
	logic mosi_ff;
	logic [1:0] miso_sync_ff;
	logic [1:0] done_sync_ff;
	logic done_d_ff;
	logic tmr_zero;

	// two-flop synchronisers for the sensor lines
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			miso_sync_ff <= 2'b11;
			done_sync_ff <= 2'b00;
			done_d_ff <= 1'b0;
			data_ready_o <= 1'b0;
		end else begin
			miso_sync_ff <= {miso_sync_ff[0], spi.miso_line};
			done_sync_ff <= {done_sync_ff[0], spi.sample_done_line};
			done_d_ff <= done_sync_ff[1];
			data_ready_o <= done_sync_ff[1] & ~done_d_ff;
		end
	end

	assign tmr_zero = (tmr_ff == '0);

	// frame sequencer: mode 3, clock idles high, msb first
	// mode 3 framing
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= H_IDLE;
			tmr_ff <= '0;
			bit_cnt_ff <= '0;
			sh_ff <= 16'h0000;
			rx_ff <= 16'h0000;
			sclk_ff <= 1'b1;
			cs_n_ff <= 1'b1;
			mosi_ff <= 1'b0;
			resp_valid_o <= 1'b0;
			resp_word_o <= 16'h0000;
		end else begin
			resp_valid_o <= 1'b0;
			if (!tmr_zero) begin
				tmr_ff <= tmr_ff - 1'b1;
			end
			case (state_ff)
				H_IDLE: begin
					if (req_valid_i) begin
						sh_ff <= req_word_i;
						mosi_ff <= req_word_i[15];
						cs_n_ff <= 1'b0;
						bit_cnt_ff <= '0;
						tmr_ff <= GSP_TMR_W'(CS_SETUP_CYC - 1);
						state_ff <= H_SETUP;
					end
				end
				H_SETUP: begin
					// first falling edge keeps the msb already on the line
					if (tmr_zero) begin
						sclk_ff <= 1'b0;
						tmr_ff <= GSP_TMR_W'(SCLK_HALF_CYC - 1);
						state_ff <= H_LOW;
					end
				end
				H_LOW: begin
					if (tmr_zero) begin
						sclk_ff <= 1'b1;
						rx_ff <= {rx_ff[14:0], miso_sync_ff[1]};
						tmr_ff <= GSP_TMR_W'(SCLK_HALF_CYC - 1);
						state_ff <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (tmr_zero) begin
						if (bit_cnt_ff == CNT_W'(GSP_FRAME_BITS - 1)) begin
							tmr_ff <= GSP_TMR_W'(CS_SETUP_CYC - 1);
							state_ff <= H_HOLD;
						end else begin
							bit_cnt_ff <= bit_cnt_ff + 1'b1;
							sclk_ff <= 1'b0;
							sh_ff <= {sh_ff[14:0], 1'b0};
							mosi_ff <= sh_ff[14];
							tmr_ff <= GSP_TMR_W'(SCLK_HALF_CYC - 1);
							state_ff <= H_LOW;
						end
					end
				end
				H_HOLD: begin
					// select stays low a little past the last rising edge
					if (tmr_zero) begin
						cs_n_ff <= 1'b1;
						resp_valid_o <= 1'b1;
						resp_word_o <= rx_ff;
						tmr_ff <= GSP_TMR_W'(STALL_CYC - 1);
						state_ff <= H_STALL;
					end
				end
				H_STALL: begin
					if (tmr_zero) begin
						state_ff <= H_IDLE;
					end
				end
				default: begin
					state_ff <= H_IDLE;
				end
			endcase
		end
	end

	assign req_ready_o = (state_ff == H_IDLE);
	assign spi.sclk = sclk_ff;
	assign spi.cs_n = cs_n_ff;
	assign spi.mosi = mosi_ff;

endmodule

// ---- tb/gsp_link_assertions.sv ----
// checker for the serial link between the host end and the device end
// assumes every link wire is sampled by the 100 MHz system clock
`timescale 1ns/10ps
module gsp_link_assertions #(
	parameter int STALL_CYC = 900
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// link wires
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_out,
	input wire logic miso_oen_n,
	input wire logic sample_done_line
);
	logic sclk_q_ff;
	logic [9:0] half_ff;
	logic [9:0] gap_ff;
	logic [4:0] rises_ff;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	// delayed serial clock for edge detection
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) sclk_q_ff <= 1'b1;
		else sclk_q_ff <= sclk;
	end

	// cycles since last sclk edge; saturates so long idles never wrap
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) half_ff <= '1;
		else if (sclk != sclk_q_ff) half_ff <= 10'h001;
		else if (half_ff != '1) half_ff <= half_ff + 10'h001;
	end

	// deselect time, starts saturated so the first frame is not flagged
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) gap_ff <= '1;
		else if (!cs_n) gap_ff <= '0;
		else if (gap_ff != '1) gap_ff <= gap_ff + 10'h001;
	end

	// rising sclk edges within the current frame
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) rises_ff <= '0;
		else if (cs_n) rises_ff <= '0;
		else if (sclk && !sclk_q_ff) rises_ff <= rises_ff + 5'h01;
	end

	property p_release;
		cs_n [*5] |-> miso_oen_n;
	endproperty
	a_release: assert property (p_release) else $error("data line held while deselected");
	property p_first_bit;
		$fell(miso_oen_n) |-> !cs_n && sclk;
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("drive began outside frame");
	property p_shift;
		!miso_oen_n && $past(!miso_oen_n) && $changed(miso_out) |-> !sclk && !$past(sclk, 2);
	endproperty
	a_shift: assert property (p_shift) else $error("output bit moved off falling sclk");
	property p_idle_high;
		cs_n |-> sclk;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("sclk low outside frame");
	property p_mosi;
		!cs_n && $past(!cs_n) && $changed(mosi) |-> !sclk || rises_ff == 5'd16;
	endproperty
	a_mosi: assert property (p_mosi) else $error("input bit moved in sclk high phase");
	property p_rate;
		sclk != sclk_q_ff |-> half_ff >= 10'd20;
	endproperty
	a_rate: assert property (p_rate) else $error("sclk phase shorter than 200 ns");
	property p_stall;
		$fell(cs_n) |-> gap_ff >= STALL_CYC;
	endproperty
	a_stall: assert property (p_stall) else $error("stall between frames too short");
	property p_frame_len;
		$rose(cs_n) |-> rises_ff == 5'd16;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame not 16 clocks");
	property p_done_pulse;
		$rose(sample_done_line) |-> sample_done_line [*4] ##1 !sample_done_line;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done pulse width wrong");
endmodule

// ---- tb/tb_gyro_spi_register_port.sv ----
// testbench: host end and device end joined by one serial link
// assumes a short sample count and the full stall; results compared with a register model
`timescale 1ns/10ps
module tb_gyro_spi_register_port;
	import gsp_pkg::*;
	localparam int SAMP = 200;
	localparam int STALL = GSP_STALL_CYC;
	logic clk_sys_i, resetn_i, req_valid_i, req_ready_o, resp_valid_o, data_ready_o;
	logic cfg_wr_o, sample_tick_o, pend_rd, started;
	logic [15:0] req_word_i, resp_word_o, gyro_sample_i, rate_ext_sample_i, temp_sample_i;
	logic [6:0] cfg_addr_o;
	logic [7:0] cfg_data_o;
	logic [14:0] last_cfg, w_last;
	logic [5:0] pend_idx;
	logic [15:0] regs [64];
	int fails, total_checks, ticks, readies, cyc, cfg_cnt, cfg_exp;

	gsp_spi_if gsp_spi_if_i ();
	gsp_host #(.STALL_CYC(STALL)) gsp_host_i (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .spi(gsp_spi_if_i),
		.req_valid_i(req_valid_i), .req_word_i(req_word_i), .req_ready_o(req_ready_o),
		.resp_valid_o(resp_valid_o), .resp_word_o(resp_word_o), .data_ready_o(data_ready_o));
	gsp_dev #(.SAMPLE_CYC(SAMP)) gsp_dev_i (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .spi(gsp_spi_if_i),
		.gyro_sample_i(gyro_sample_i), .rate_ext_sample_i(rate_ext_sample_i),
		.temp_sample_i(temp_sample_i), .cfg_wr_o(cfg_wr_o), .cfg_addr_o(cfg_addr_o),
		.cfg_data_o(cfg_data_o), .sample_tick_o(sample_tick_o));
	gsp_link_assertions #(.STALL_CYC(STALL)) gsp_link_assertions_i (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sclk(gsp_spi_if_i.sclk),
		.cs_n(gsp_spi_if_i.cs_n), .mosi(gsp_spi_if_i.mosi), .miso_out(gsp_spi_if_i.miso_out),
		.miso_oen_n(gsp_spi_if_i.miso_oen_n), .sample_done_line(gsp_spi_if_i.sample_done_line));

	// system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// event counters, cleared with the design so counts line up
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			{ticks, readies, cyc, cfg_cnt} = '0;
		end else begin
			cyc++;
			ticks += int'(sample_tick_o === 1'b1);
			readies += int'(data_ready_o === 1'b1);
			if (cfg_wr_o === 1'b1) begin
				cfg_cnt++;
				last_cfg = {cfg_addr_o, cfg_data_o};
			end
		end
	end

	task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// reset both ends and the model; sample inputs get fresh random values
	task automatic do_reset();
		@(posedge clk_sys_i);
		resetn_i <= 1'b0;
		gyro_sample_i <= 16'($urandom());
		rate_ext_sample_i <= 16'($urandom());
		temp_sample_i <= 16'($urandom());
		repeat (4) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		foreach (regs[i]) regs[i] = 16'h0000;
		regs[GSP_ADDR_SCALE[6:1]] = GSP_RST_SCALE;
		regs[GSP_ADDR_MISC[6:1]] = GSP_RST_MISC;
		regs[GSP_ADDR_AVG[6:1]] = GSP_RST_AVG;
		regs[GSP_ADDR_PROD[6:1]] = GSP_RST_PROD;
		regs[GSP_ADDR_GYRO[6:1]] = gyro_sample_i;
		regs[GSP_ADDR_RATE_EXT[6:1]] = rate_ext_sample_i;
		regs[GSP_ADDR_TEMP[6:1]] = temp_sample_i;
		{pend_rd, started, cfg_exp} = '0;
	endtask

	// one frame: hand over the word, wait for the shifted-in word, compare
	task automatic frame(input logic [15:0] w);
		int n;
		logic [15:0] exp;
		n = 0;
		exp = pend_rd ? regs[pend_idx] : 16'hffff;
		check16(16'(cfg_cnt), 16'(cfg_exp), "write count");
		if (cfg_exp > 0) check16({1'b0, last_cfg}, {1'b0, w_last}, "write echo");
		req_valid_i <= 1'b1;
		req_word_i <= w;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 3000);
		req_valid_i <= 1'b0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (resp_valid_o !== 1'b1 && n < 6000);
		if (n >= 6000) begin
			fails++;
			$display("Error at %0t ns: frame timed out", $time);
			conclude();
		end
		if (started) check16(resp_word_o, exp, "response");
		if (w[15] && w[14:8] >= GSP_ADDR_RW_FIRST) begin
			if (w[8]) regs[w[14:9]][15:8] = w[7:0];
			else regs[w[14:9]][7:0] = w[7:0];
			cfg_exp++;
			w_last = w[14:0];
		end
		pend_rd = !w[15];
		pend_idx = w[14:9];
		started = 1'b1;
	endtask

	// main sequence
	initial begin
		logic [15:0] w;
		bit ok;
		{fails, total_checks} = '0;
		resetn_i = 1'b0;
		req_valid_i = 1'b0;
		req_word_i = 16'h0000;
		{gyro_sample_i, rate_ext_sample_i, temp_sample_i} = '0;
		void'($urandom(32'hca53_dbc9));
		do_reset();
		frame(16'h0400);
		frame(16'h0600);
		frame(16'h0c00);
		frame(16'h0400);
		frame(16'h1600);
		frame(16'h3501);
		frame(16'h3800);
		frame(16'h5600);
		frame(16'h96aa);
		frame(16'h1700);
		frame(16'h8455);
		for (int k = 0; k < 24; k++) begin
			w = 16'($urandom());
			if (k % 3 == 0) w[14:8] = 7'h14 + 7'($urandom_range(0, 107));
			frame(w);
		end
		do_reset();
		frame(16'h1600);
		frame(16'h0c01);
		frame(16'h0000);
		ok = (ticks == cyc / SAMP || ticks == cyc / SAMP - 1) && readies >= ticks - 1;
		check16({15'h0000, ok}, 16'h0001, "sample ticks");
		conclude();
	end
endmodule
